//--- pkg/cdmc_regs.svh
/*
 * constants for the configurable direct-mapped cache: geometry, address slices,
 * organisation codes. assumes it is included by bare name after the package.
 */
`ifndef CDMC_REGS_SVH
`define CDMC_REGS_SVH

`define CDMC_NUM_LINES      128
`define CDMC_DATA_WORDS     512
`define CDMC_LINE_AW        7
`define CDMC_WORD_AW        9
`define CDMC_TAG_W          22
`define CDMC_TAG_MSB        31
`define CDMC_TAG_LSB        10
`define CDMC_FULL_IDX_MSB   10
`define CDMC_SPLIT_IDX_MSB  9
`define CDMC_IDX_LSB        4
`define CDMC_WSEL_MSB       3
`define CDMC_WSEL_LSB       2
`define CDMC_LAST_BEAT      2'h3
`define CDMC_ORG_ICACHE     2'h0
`define CDMC_ORG_DCACHE     2'h1
`define CDMC_ORG_SPLIT      2'h2

`endif

//--- pkg/cdmc_pkg.sv
/*
 * types shared by the cache files.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cdmc_pkg;
    typedef enum logic [2:0] {
        CDMC_IDLE,
        CDMC_LOOK,
        CDMC_RD_BUS,
        CDMC_WR_BUS,
        CDMC_FILL
    } cdmc_state_t;
endpackage

//--- pkg/cdmc_ram_if.sv
/*
 * port bundle between the cache controller and one storage array.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface cdmc_ram_if #(parameter int AW = 9, parameter int DW = 32);
    logic [AW-1:0] addr;
    logic          we;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport user (output addr, output we, output wdata, input rdata);
    modport ram  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

//--- verilog/cdmc_ram.sv
/*
 * single-port storage array with registered read data.
 * assumes address and write strobe are stable before the clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module cdmc_ram #(
    parameter int AW    = 9,
    parameter int DW    = 32,
    parameter int DEPTH = 512
) (
    input wire logic core_clk,
    cdmc_ram_if.ram  port
);
    logic [DW-1:0] mem [DEPTH];

    // no reset on the array; contents only count behind a valid bit
    always_ff @(posedge core_clk)
    begin
        if (port.we)
        begin
            mem[port.addr] <= port.wdata;
            port.rdata     <= port.wdata;
        end
        else
        begin
            port.rdata <= mem[port.addr];
        end
    end
endmodule
`default_nettype wire

//--- verilog/cdmc_cache.sv
/*
 * configurable direct-mapped cache controller: lookup, line fill, write-through.
 * assumes core and system bus logic share core_clk; the system bus answers each
 * beat with a one-cycle sys_ack and holds no request of its own.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cdmc_regs.svh"

// What this block does
// - three organisations: instruction, data, split halves
// - direct mapped; hit answered after one lookup
// - 128 lines of 16 bytes each
// - 128-entry tag array with valid bits
// - 512 x 32 data array, four words/line
// - tag and data arrays read in parallel
// - instruction-only: tag [10:4], data [10:2]
// - data-only: tag [10:4], data [10:2]
// - split: top index bit from access type
// - cacheable read miss fetches 16-byte line into buffer
// - every operand write goes to system bus
module cdmc_cache
    import cdmc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [1:0]  cache_organization_control,
    input  wire logic        core_req,
    input  wire logic        core_ifetch,
    input  wire logic        core_we,
    input  wire logic [31:0] core_addr,
    input  wire logic [31:0] core_wdata,
    input  wire logic [3:0]  core_be,
    output logic             core_ready,
    output logic             core_ack,
    output logic [31:0]      core_rdata,
    output logic             sys_req,
    output logic             sys_we,
    output logic             sys_burst,
    output logic [31:0]      sys_addr,
    output logic [31:0]      sys_wdata,
    output logic [3:0]       sys_be,
    input  wire logic        sys_ack,
    input  wire logic [31:0] sys_rdata
);
    cdmc_state_t                  state_reg;
    cdmc_state_t                  state_next;
    logic [`CDMC_NUM_LINES-1:0]   valid_reg;
    logic [1:0]                   org_reg;
    logic [31:0]                  addr_reg;
    logic                         ifetch_reg;
    logic                         we_reg;
    logic [31:0]                  wdata_reg;
    logic [3:0]                   be_reg;
    logic                         hit_reg;
    logic [31:0]                  merge_reg;
    logic [1:0]                   cnt_reg;
    logic [31:0]                  fill_reg [4];

    cdmc_ram_if #(.AW(`CDMC_WORD_AW), .DW(32))         data_if ();
    cdmc_ram_if #(.AW(`CDMC_LINE_AW), .DW(`CDMC_TAG_W)) tag_if ();

    cdmc_ram #(.AW(`CDMC_WORD_AW), .DW(32), .DEPTH(`CDMC_DATA_WORDS)) data_ram (
        .core_clk (core_clk),
        .port     (data_if.ram)
    );

    cdmc_ram #(.AW(`CDMC_LINE_AW), .DW(`CDMC_TAG_W), .DEPTH(`CDMC_NUM_LINES)) tag_ram (
        .core_clk (core_clk),
        .port     (tag_if.ram)
    );

    function automatic logic [`CDMC_LINE_AW-1:0] line_index(
        input logic [31:0] a,
        input logic        f,
        input logic [1:0]  org
    );
        if (org == `CDMC_ORG_SPLIT)
            line_index = {~f, a[`CDMC_SPLIT_IDX_MSB:`CDMC_IDX_LSB]};
        else
            line_index = a[`CDMC_FULL_IDX_MSB:`CDMC_IDX_LSB];
    endfunction

    // unknown organisation code caches nothing
    wire logic cacheable = (org_reg == `CDMC_ORG_SPLIT)
                        || (org_reg == `CDMC_ORG_ICACHE && ifetch_reg)
                        || (org_reg == `CDMC_ORG_DCACHE && !ifetch_reg);

    wire logic [`CDMC_LINE_AW-1:0] idx_core = line_index(core_addr, core_ifetch, org_reg);
    wire logic [`CDMC_LINE_AW-1:0] idx_held = line_index(addr_reg, ifetch_reg, org_reg);
    wire logic [1:0] wsel_core = core_addr[`CDMC_WSEL_MSB:`CDMC_WSEL_LSB];
    wire logic [1:0] wsel_held = addr_reg[`CDMC_WSEL_MSB:`CDMC_WSEL_LSB];

    wire logic in_idle = (state_reg == CDMC_IDLE);
    wire logic in_fill = (state_reg == CDMC_FILL);
    wire logic take    = in_idle && core_req;
    wire logic last_beat = sys_ack && (!sys_burst || cnt_reg == `CDMC_LAST_BEAT);
    wire logic fill_end  = in_fill && cnt_reg == `CDMC_LAST_BEAT;

    // both arrays see the same index in the same cycle
    wire logic [`CDMC_LINE_AW-1:0] idx_sel = in_idle ? idx_core : idx_held;
    wire logic [1:0] wsel_sel = in_idle ? wsel_core : (in_fill ? cnt_reg : wsel_held);

    assign data_if.addr  = {idx_sel, wsel_sel};
    assign tag_if.addr   = idx_sel;
    assign data_if.we    = in_fill || (state_reg == CDMC_WR_BUS && sys_ack && hit_reg);
    assign data_if.wdata = in_fill ? fill_reg[cnt_reg] : merge_reg;
    assign tag_if.we     = fill_end;
    assign tag_if.wdata  = addr_reg[`CDMC_TAG_MSB:`CDMC_TAG_LSB];

    // full mode stores addr[10] too; it equals the index bit, so one compare fits all modes
    wire logic hit = cacheable && valid_reg[idx_held]
                  && tag_if.rdata == addr_reg[`CDMC_TAG_MSB:`CDMC_TAG_LSB];

    // byte lanes picked one by one so a partial write keeps the cached neighbours
    wire logic [31:0] merged;
    for (genvar b = 0; b < 4; b++)
    begin
        assign merged[b*8 +: 8] = be_reg[b] ? wdata_reg[b*8 +: 8] : data_if.rdata[b*8 +: 8];
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            CDMC_IDLE:
                if (core_req)
                    state_next = CDMC_LOOK;
            CDMC_LOOK:
                if (we_reg)
                    state_next = CDMC_WR_BUS;
                else if (!hit)
                    state_next = CDMC_RD_BUS;
                else
                    state_next = CDMC_IDLE;
            CDMC_RD_BUS:
                if (last_beat)
                    state_next = sys_burst ? CDMC_FILL : CDMC_IDLE;
            CDMC_WR_BUS:
                if (sys_ack)
                    state_next = CDMC_IDLE;
            CDMC_FILL:
                if (cnt_reg == `CDMC_LAST_BEAT)
                    state_next = CDMC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg  <= CDMC_IDLE;
            core_ready <= 1'h1;
        end
        else
        begin
            state_reg  <= state_next;
            core_ready <= (state_next == CDMC_IDLE);
        end
    end

    always_ff @(posedge core_clk)
    begin
        org_reg <= cache_organization_control;
        // a new organisation can remap lines or change which accesses are cached, so stale lines must not hit
        if (rst || org_reg != cache_organization_control)
            valid_reg <= '0;
        else if (fill_end)
            valid_reg[idx_held] <= 1'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (take)
        begin
            addr_reg   <= core_addr;
            ifetch_reg <= core_ifetch;
            we_reg     <= core_we;
            wdata_reg  <= core_wdata;
            be_reg     <= core_be;
        end
        if (state_reg == CDMC_LOOK)
        begin
            hit_reg   <= hit;
            merge_reg <= merged;
        end
        if (state_reg == CDMC_RD_BUS && sys_ack)
            fill_reg[cnt_reg] <= sys_rdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            cnt_reg <= 2'h0;
        else if (state_reg == CDMC_LOOK || last_beat && state_reg == CDMC_RD_BUS)
            cnt_reg <= 2'h0;
        else if ((state_reg == CDMC_RD_BUS && sys_ack) || in_fill)
            cnt_reg <= cnt_reg + 2'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            core_ack   <= 1'h0;
            core_rdata <= 32'h0;
        end
        else
        begin
            core_ack <= 1'h0;
            if (state_reg == CDMC_LOOK && !we_reg && hit)
            begin
                core_ack   <= 1'h1;
                core_rdata <= data_if.rdata;
            end
            else if (state_reg == CDMC_RD_BUS && last_beat && !sys_burst)
            begin
                core_ack   <= 1'h1;
                core_rdata <= sys_rdata;
            end
            else if (fill_end)
            begin
                core_ack   <= 1'h1;
                core_rdata <= fill_reg[wsel_held];
            end
            else if (state_reg == CDMC_WR_BUS && sys_ack)
            begin
                core_ack <= 1'h1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sys_req   <= 1'h0;
            sys_we    <= 1'h0;
            sys_burst <= 1'h0;
            sys_addr  <= 32'h0;
            sys_wdata <= 32'h0;
            sys_be    <= 4'h0;
        end
        else if (state_reg == CDMC_LOOK && (we_reg || !hit))
        begin
            sys_req   <= 1'h1;
            sys_we    <= we_reg;
            sys_burst <= !we_reg && cacheable;
            sys_addr  <= (!we_reg && cacheable) ? {addr_reg[`CDMC_TAG_MSB:`CDMC_IDX_LSB], 4'h0}
                                                 : {addr_reg[`CDMC_TAG_MSB:`CDMC_WSEL_LSB], 2'h0};
            sys_wdata <= wdata_reg;
            sys_be    <= we_reg ? be_reg : 4'hf;
        end
        else if ((state_reg == CDMC_RD_BUS && last_beat)
              || (state_reg == CDMC_WR_BUS && sys_ack))
        begin
            sys_req <= 1'h0;
        end
    end
endmodule
`default_nettype wire

//--- dv/cdmc_sysmem.sv
/* system bus memory model, answers each beat after dly idle cycles.
   assumes the cache holds sys_* stable until its last ack. */
`timescale 1ns/10ps
`default_nettype none
module cdmc_sysmem (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        sys_req,
    input wire logic        sys_we,
    input wire logic        sys_burst,
    input wire logic [31:0] sys_addr,
    input wire logic [31:0] sys_wdata,
    input wire logic [3:0]  sys_be,
    input wire logic [1:0]  dly,
    output logic            sys_ack,
    output logic [31:0]     sys_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] a;
    logic [31:0] m;
    logic [31:0] bm;
    int          beat;
    int          wt;
    int          nbeat;
    assign bm = {{8{sys_be[3]}}, {8{sys_be[2]}}, {8{sys_be[1]}}, {8{sys_be[0]}}};
    assign nbeat = sys_burst ? 4 : 1;
    always @(posedge core_clk)
    begin
        sys_ack <= 1'b0;
        // inverted filler so stale data never looks valid
        sys_rdata <= ~sys_rdata;
        a = sys_addr + 32'(beat * 4);
        m = mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
        if (rst || !sys_req)
        begin
            beat = 0;
            wt = 0;
        end
        else if (beat < nbeat && wt < int'(dly))
            wt++;
        else if (beat < nbeat)
        begin
            wt = 0;
            beat++;
            sys_ack <= 1'b1;
            sys_rdata <= m;
            if (sys_we)
                mem[a] = (m & ~bm) | (sys_wdata & bm);
        end
    end
endmodule
`default_nettype wire

//--- dv/cdmc_cache_chk.sv
/* port assertions for the cache controller.
   assumes one clock and synchronous active-high rst. */
`timescale 1ns/10ps
`default_nettype none
module cdmc_cache_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        core_req,
    input wire logic        core_we,
    input wire logic [31:0] core_addr,
    input wire logic [31:0] core_wdata,
    input wire logic [3:0]  core_be,
    input wire logic        core_ready,
    input wire logic        core_ack,
    input wire logic        sys_req,
    input wire logic        sys_we,
    input wire logic        sys_burst,
    input wire logic [31:0] sys_addr,
    input wire logic [31:0] sys_wdata,
    input wire logic [3:0]  sys_be,
    input wire logic        sys_ack
);
    logic [1:0] beats_reg;
    logic       take;
    assign take = core_req && core_ready;
    always_ff @(posedge core_clk)
        if (rst || !sys_req)
            beats_reg <= 2'h0;
        else if (sys_ack)
            beats_reg <= beats_reg + 2'h1;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_last_beat;
        sys_req && sys_burst && sys_ack && beats_reg == 2'h3;
    endsequence
    sequence s_fill_done;
        !sys_req ##4 core_ack;
    endsequence
    property p_take; take |=> !core_ready; endproperty
    a_take: assert property (p_take) else $error("ready high after take");
    property p_ack_pulse; core_ack |=> !core_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_wr_bus;
        take && core_we |-> ##2 sys_req && sys_we && sys_wdata == $past(core_wdata, 2)
            && sys_addr == ($past(core_addr, 2) & 32'hffff_fffc)
            && sys_be == $past(core_be, 2);
    endproperty
    a_wr_bus: assert property (p_wr_bus) else $error("write not on bus");
    property p_burst_align; $rose(sys_req) && sys_burst |-> sys_addr[3:0] == 4'h0 && !sys_we;
    endproperty
    a_burst_align: assert property (p_burst_align) else $error("bad burst");
    property p_rd_be; $rose(sys_req) && !sys_we |-> sys_be == 4'hf; endproperty
    a_rd_be: assert property (p_rd_be) else $error("read strobes not all set");
    property p_stable;
        sys_req && !sys_ack |=> sys_req && $stable(sys_addr) && $stable(sys_burst)
            && $stable(sys_we) && $stable(sys_wdata) && $stable(sys_be);
    endproperty
    a_stable: assert property (p_stable) else $error("bus request moved");
    property p_last_beat; s_last_beat |=> s_fill_done; endproperty
    a_last_beat: assert property (p_last_beat) else $error("fill timing wrong");
    property p_mid_beat; sys_req && sys_burst && sys_ack && beats_reg != 2'h3 |=> sys_req;
    endproperty
    a_mid_beat: assert property (p_mid_beat) else $error("burst cut short");
    property p_single; sys_req && !sys_burst && sys_ack |=> !sys_req; endproperty
    a_single: assert property (p_single) else $error("single beat overran");
    property p_wr_ack; sys_req && sys_we && sys_ack |=> core_ack && core_ready; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write not completed");
endmodule
bind cdmc_cache cdmc_cache_chk cdmc_cache_chk_i (.core_clk, .rst, .core_req, .core_we,
    .core_addr, .core_wdata, .core_be, .core_ready, .core_ack, .sys_req, .sys_we, .sys_burst,
    .sys_addr, .sys_wdata, .sys_be, .sys_ack);
`default_nettype wire

//--- dv/cdmc_cache_tb.sv
/* self-checking bench: cache against the system bus memory model.
   assumes cdmc_regs.svh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "cdmc_regs.svh"
module cdmc_cache_tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  org = `CDMC_ORG_ICACHE;
    logic        core_req = 1'b0;
    logic        core_ifetch = 1'b0;
    logic        core_we = 1'b0;
    logic [31:0] core_addr = 32'h0;
    logic [31:0] core_wdata = 32'h0;
    logic [3:0]  core_be = 4'h0;
    logic [1:0]  dly = 2'h0;
    logic        prev_req = 1'b0;
    logic        core_ready, core_ack, sys_req, sys_we, sys_burst, sys_ack;
    logic [31:0] core_rdata, sys_addr, sys_wdata, sys_rdata;
    logic [3:0]  sys_be;
    int          errors, n_checks, nb, ns;
    always #10 core_clk = ~core_clk;
    cdmc_cache cdmc_cache_i (.core_clk, .rst, .cache_organization_control(org), .core_req,
        .core_ifetch, .core_we, .core_addr, .core_wdata, .core_be, .core_ready, .core_ack,
        .core_rdata, .sys_req, .sys_we, .sys_burst, .sys_addr, .sys_wdata, .sys_be,
        .sys_ack, .sys_rdata);
    cdmc_sysmem cdmc_sysmem_i (.core_clk, .rst, .sys_req, .sys_we, .sys_burst, .sys_addr,
        .sys_wdata, .sys_be, .dly, .sys_ack, .sys_rdata);
    always @(posedge core_clk)
    begin
        prev_req <= sys_req;
        nb += int'(sys_req && !prev_req && sys_burst);
        ns += int'(sys_req && !prev_req && !sys_burst);
    end
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    task end_sim;
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic f, input logic w, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] q, output int lat);
        int n;
        {core_req, core_ifetch, core_we} <= {1'b1, f, w};
        {core_addr, core_wdata, core_be} <= {a, d, be};
        n = 0;
        do begin @(posedge core_clk); n++; end while (core_ready !== 1'b1 && n < 50);
        core_req <= 1'b0;
        // never taken: count it, the ack wait below then runs out as well
        if (core_ready !== 1'b1)
            errors++;
        lat = 0;
        do begin @(posedge core_clk); lat++; end while (core_ack !== 1'b1 && lat < 200);
        q = core_rdata;
        if (lat >= 200)
            errors++;
    endtask
    // m: 0 hit, 1 line burst, 2 single bypass read
    task automatic rd(input logic f, input logic [31:0] a, input logic [31:0] e, input int m);
        int b0, s0, lat;
        logic [31:0] q;
        b0 = nb;
        s0 = ns;
        acc(f, 1'b0, a, 32'h0, 4'h0, q, lat);
        chk(q, e);
        chk(32'(nb - b0), 32'(m == 1));
        chk(32'(ns - s0), 32'(m == 2));
        if (m == 0)
            chk(32'(lat), 32'h2);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int b0, s0, lat;
        logic [31:0] q;
        b0 = nb;
        s0 = ns;
        acc(1'b0, 1'b1, a, d, 4'h3, q, lat);
        chk(32'(ns - s0), 32'h1);
        chk(32'(nb - b0), 32'h0);
    endtask
    // low half from the write, high half from memory
    function automatic logic [31:0] mg(input logic [31:0] a, input logic [31:0] d);
        return (pat(a) & 32'hffff_0000) | (d & 32'h0000_ffff);
    endfunction
    task set_org(input logic [1:0] o);
        org <= o;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic t_full(input logic [1:0] o);
        logic f;
        logic [31:0] a;
        f = (o == `CDMC_ORG_ICACHE);
        a = 32'h0000_1230;
        set_org(o);
        rd(f, a, pat(a), 1);
        rd(f, a + 32'h4, pat(a + 32'h4), 0);
        rd(!f, a, pat(a), 2);
        rd(f, a ^ 32'h400, pat(a ^ 32'h400), 1);
        rd(f, a, pat(a), 0);
        rd(f, a + 32'h800, pat(a + 32'h800), 1);
        rd(f, a, pat(a), 1);
    endtask
    task automatic t_split;
        logic [31:0] a;
        a = 32'h0000_1230;
        set_org(`CDMC_ORG_SPLIT);
        rd(1'b1, a, pat(a), 1);
        rd(1'b0, a, pat(a), 1);
        rd(1'b1, a, pat(a), 0);
        rd(1'b0, a ^ 32'h400, pat(a ^ 32'h400), 1);
        rd(1'b0, a, pat(a), 1);
        rd(1'b1, a, pat(a), 0);
        set_org(2'h3);
        rd(1'b1, a, pat(a), 2);
    endtask
    task automatic t_write;
        logic [31:0] b, d;
        b = 32'h0000_2560;
        d = 32'hdead_beef;
        set_org(`CDMC_ORG_DCACHE);
        dly <= 2'h2;
        rd(1'b0, b, pat(b), 1);
        wr(b, d);
        rd(1'b0, b, mg(b, d), 0);
        wr(b + 32'h10, d);
        rd(1'b0, b + 32'h10, mg(b + 32'h10, d), 1);
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        chk(32'({core_ready, core_ack, sys_req}), 32'h4);
        rst <= 1'b0;
        t_full(`CDMC_ORG_ICACHE);
        t_full(`CDMC_ORG_DCACHE);
        t_split;
        t_write;
        end_sim;
    end
    // a whole run is well under 2000 cycles
    initial
    begin
        #200000;
        errors++;
        end_sim;
    end
endmodule
`default_nettype wire
